// ---- logic/accel_data_port.sv ----
// Purpose: Core-side data transfer port toward hardware accelerators
// Assumes: Active-low handshake lines; bus inputs synchronous to clk
// Notes: Clock phases are modelled as the two halves of one clk cycle
`timescale 1ns/1ps
`include "accel_port_cfg.svh"
// How it works
// - Hold last busy/exception sample in latch.
// - Drive bus high phase, capture low.
// - Transfer count registers from R4, max seven.
// - Strobe held through pipelined register transfers.
// - Drive next operand early; repeat on nack.
// - Return values written straight each clock.
// - Strobe changes rising; ack sampled low.
// - Load strobes valid operand, ignores ack.
// - Load strobe delayed by memory waits.
// - Update address driven in the execute cycle.
// - Memory access fault asserts error output.
// - Half-word store writes only lower half.
// - Store requests memory on ack, data next.
// - Store strobe after memory write completes.
// - Exception sampled on decode without busy.
// - Execute only after busy negated.
// - Call/return count zero is execute-only, no transfer.
module accel_data_port (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`OP_W-1:0] accel_opcode,
   input wire logic accel_decode_strobe_n,
   input wire logic accelBusyIn_n,
   input wire logic accel_exception_n,
   input wire logic issueReq,
   input wire logic issueUpdate,
   input wire logic [`DATA_W-1:0] effAddr,
   output logic accelExecute_n,
   output logic accelExcTaken,
   input wire logic [`DATA_W-1:0] accelBusIn,
   output logic [`DATA_W-1:0] accelBusOut,
   output logic accelBusOe,
   output logic xfer_strobe_n,
   input wire logic xfer_ack_n,
   output logic xferError_n,
   output logic [`GPR_IDX_W-1:0] regRdIdx,
   input wire logic [`DATA_W-1:0] regRdData,
   output logic regWrEn,
   output logic [`GPR_IDX_W-1:0] regWrIdx,
   output logic [`DATA_W-1:0] regWrData,
   output logic memReq,
   output logic memWrite,
   output logic memHalf,
   output logic [`DATA_W-1:0] memWrData,
   input wire logic memDone,
   input wire logic [`DATA_W-1:0] memRdData,
   input wire logic memFault,
   output logic portIdle
);
   accel_port_pkg::xfer_state_t state_reg;
   accel_port_pkg::xfer_state_t state_next;
   accel_port_pkg::xfer_op_t op_reg;
   logic busyHold_reg;
   logic excHold_reg;
   logic [2:0] left_reg;
   logic [`GPR_IDX_W-1:0] idx_reg;
   logic [`DATA_W-1:0] out_reg;
   logic oe_reg;
   logic strobe_reg;
   logic err_reg;
   logic half_reg;
   logic [`DATA_W-1:0] stData_reg;
   logic exec_reg;
   logic exc_reg;
   logic regWr_reg;
   logic [`GPR_IDX_W-1:0] regWrIdx_reg;
   logic [`DATA_W-1:0] regWrData_reg;
   logic memReq_reg;
   logic memWr_reg;
   logic [`DATA_W-1:0] memWrData_reg;
   wire logic decodeOn;
   wire logic busyNow;
   wire logic excNow;
   wire logic [2:0] cnt;
   wire logic isMem;
   wire logic isStoreOp;
   wire logic isRetOp;
   wire logic execOnly;
   wire logic canIssue;
   wire logic ackSeen;
   wire logic fifoInValid;
   wire logic fifoInReady;
   wire logic fifoOutValid;
   wire logic [`DATA_W-1:0] fifoOutData;
   wire logic fifoPop;
   wire logic callDrive;
   // Latch hold: the sampled value stands while no unit drives
   assign decodeOn = !accel_decode_strobe_n;
   assign busyNow = decodeOn ? !accelBusyIn_n : busyHold_reg;
   assign excNow = decodeOn ? !accel_exception_n : excHold_reg;
   assign cnt = accel_opcode[`CNT_HI:`CNT_LO];
   assign isMem = accel_opcode[9];
   assign isStoreOp = accel_opcode[7];
   assign isRetOp = !accel_opcode[7] && !isMem && accel_opcode[8];
   assign execOnly = !isMem && (cnt == 3'h0);
   assign canIssue = decodeOn && !busyNow && issueReq && (state_reg == accel_port_pkg::ST_IDLE);
   assign ackSeen = !xfer_ack_n;
   // Call operands go through the FIFO so a nack replays the held word
   assign fifoInValid = (state_reg == accel_port_pkg::ST_CALL) && (left_reg != 3'h0);
   assign callDrive = (state_reg == accel_port_pkg::ST_CALL);
   // Head word stands on the bus until acknowledged, so a nack repeats it
   assign fifoPop = callDrive && fifoOutValid && ackSeen;
   xfer_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) callFifo (
      .clk(clk),
      .rst(rst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(regRdData),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData)
   );
   assign regRdIdx = idx_reg;
   assign accelBusOut = callDrive ? fifoOutData : out_reg;
   assign accelBusOe = callDrive ? fifoOutValid : oe_reg;
   assign xfer_strobe_n = !strobe_reg;
   assign xferError_n = !err_reg;
   assign accelExecute_n = !exec_reg;
   assign accelExcTaken = exc_reg;
   assign regWrEn = regWr_reg;
   assign regWrIdx = regWrIdx_reg;
   assign regWrData = regWrData_reg;
   assign memReq = memReq_reg;
   assign memWrite = memWr_reg;
   assign memHalf = half_reg;
   assign memWrData = memWrData_reg;
   assign portIdle = (state_reg == accel_port_pkg::ST_IDLE);
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         accel_port_pkg::ST_IDLE: begin
            if (canIssue && !excNow && !execOnly) begin
               if (isMem && issueUpdate) state_next = accel_port_pkg::ST_UPD;
               else if (isMem) state_next = isStoreOp ? accel_port_pkg::ST_STACK
                  : accel_port_pkg::ST_LDWAIT;
               else state_next = isRetOp ? accel_port_pkg::ST_RET : accel_port_pkg::ST_CALL;
            end
         end
         accel_port_pkg::ST_UPD: state_next = (op_reg == accel_port_pkg::OP_STORE)
            ? accel_port_pkg::ST_STACK : accel_port_pkg::ST_LDWAIT;
         accel_port_pkg::ST_CALL: begin
            if (left_reg == 3'h0 && !fifoOutValid) state_next = accel_port_pkg::ST_IDLE;
         end
         accel_port_pkg::ST_RET: begin
            if (left_reg == 3'h1 && ackSeen) state_next = accel_port_pkg::ST_IDLE;
         end
         accel_port_pkg::ST_LDWAIT: begin
            if (memDone || memFault) state_next = accel_port_pkg::ST_DONE;
         end
         accel_port_pkg::ST_STACK: begin
            if (ackSeen) state_next = accel_port_pkg::ST_STMEM;
         end
         accel_port_pkg::ST_STMEM: begin
            if (memDone || memFault) state_next = accel_port_pkg::ST_DONE;
         end
         accel_port_pkg::ST_DONE: state_next = accel_port_pkg::ST_IDLE;
         default: state_next = accel_port_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         busyHold_reg <= 1'b0;
         excHold_reg <= 1'b0;
      end else if (decodeOn) begin
         busyHold_reg <= !accelBusyIn_n;
         excHold_reg <= !accel_exception_n;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= accel_port_pkg::ST_IDLE;
         op_reg <= accel_port_pkg::OP_NONE;
         exec_reg <= 1'b0;
         exc_reg <= 1'b0;
         half_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         exec_reg <= canIssue;
         exc_reg <= canIssue && excNow;
         if (canIssue) begin
            half_reg <= !accel_opcode[8];
            op_reg <= isMem ? (isStoreOp ? accel_port_pkg::OP_STORE : accel_port_pkg::OP_LOAD)
               : (isRetOp ? accel_port_pkg::OP_RET : accel_port_pkg::OP_CALL);
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         left_reg <= 3'h0;
         idx_reg <= `FIRST_REG;
      end else if (canIssue) begin
         left_reg <= cnt;
         idx_reg <= `FIRST_REG;
      end else if (fifoInValid && fifoInReady) begin
         left_reg <= left_reg - 3'h1;
         idx_reg <= idx_reg + 4'h1;
      end else if (state_reg == accel_port_pkg::ST_RET && ackSeen) begin
         left_reg <= left_reg - 3'h1;
         idx_reg <= idx_reg + 4'h1;
      end
   end
   // Bus drive and strobe, all changed on the rising edge
   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg <= '0;
         oe_reg <= 1'b0;
         strobe_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         oe_reg <= 1'b0;
         strobe_reg <= 1'b0;
         err_reg <= 1'b0;
         case (state_next)
            accel_port_pkg::ST_UPD: begin
               out_reg <= effAddr;
               oe_reg <= 1'b1;
            end
            accel_port_pkg::ST_CALL: begin
               strobe_reg <= 1'b1;
            end
            accel_port_pkg::ST_RET: strobe_reg <= 1'b1;
            accel_port_pkg::ST_DONE: begin
               strobe_reg <= 1'b1;
               err_reg <= memFault;
               if (op_reg == accel_port_pkg::OP_LOAD) begin
                  out_reg <= memRdData;
                  oe_reg <= 1'b1;
               end
            end
            default: oe_reg <= 1'b0;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         regWr_reg <= 1'b0;
         regWrIdx_reg <= '0;
         regWrData_reg <= '0;
         memReq_reg <= 1'b0;
         memWr_reg <= 1'b0;
         memWrData_reg <= '0;
         stData_reg <= '0;
      end else begin
         regWr_reg <= (state_reg == accel_port_pkg::ST_RET) && ackSeen;
         regWrIdx_reg <= idx_reg;
         regWrData_reg <= accelBusIn;
         memReq_reg <= 1'b0;
         memWr_reg <= 1'b0;
         if (state_reg == accel_port_pkg::ST_STACK && ackSeen) begin
            memReq_reg <= 1'b1;
            memWr_reg <= 1'b1;
            stData_reg <= half_reg ? {{`HALF_W{1'b0}}, accelBusIn[`HALF_W-1:0]}
               : accelBusIn;
         end else if (state_reg == accel_port_pkg::ST_UPD && op_reg == accel_port_pkg::OP_LOAD)
         begin
            memReq_reg <= 1'b1;
         end else if (canIssue && isMem && !isStoreOp && !issueUpdate && !excNow) begin
            memReq_reg <= 1'b1;
         end
         if (state_reg == accel_port_pkg::ST_STMEM) memWrData_reg <= stData_reg;
      end
   end
   a_exec_after_free: assert property (@(posedge clk) disable iff (rst)
      !accelExecute_n |-> $past(decodeOn) && !$past(busyNow)) else $error("execute while busy");
   a_exc_sample: assert property (@(posedge clk) disable iff (rst)
      accelExcTaken |-> !accelExecute_n) else $error("exception without execute");
   a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
      $past(portIdle) && portIdle |-> xfer_strobe_n && xferError_n) else $error("idle strobe");
   a_store_req_ack: assert property (@(posedge clk) disable iff (rst)
      state_reg == accel_port_pkg::ST_STACK && ackSeen |=> memReq && memWrite) else
      $error("store request late");
   a_store_data_next: assert property (@(posedge clk) disable iff (rst)
      memReq && memWrite |=> state_reg != accel_port_pkg::ST_STMEM || memWrData == stData_reg)
      else $error("store data not driven");
   a_half_upper_zero: assert property (@(posedge clk) disable iff (rst)
      memReq && memWrite && memHalf |-> stData_reg[31:16] == 16'h0000) else
      $error("half store upper bits");
   a_fault_error: assert property (@(posedge clk) disable iff (rst)
      (state_reg == accel_port_pkg::ST_LDWAIT || state_reg == accel_port_pkg::ST_STMEM)
      && memFault |=> !xferError_n && !xfer_strobe_n) else $error("fault not flagged");
   a_ret_write: assert property (@(posedge clk) disable iff (rst)
      state_reg == accel_port_pkg::ST_RET && ackSeen |=> regWrEn && regWrData == $past(accelBusIn))
      else $error("return word lost");
   a_update_drive: assert property (@(posedge clk) disable iff (rst)
      state_reg == accel_port_pkg::ST_UPD |-> accelBusOe && accelBusOut == $past(effAddr))
      else $error("update address missing");
   a_call_strobe: assert property (@(posedge clk) disable iff (rst)
      state_reg == accel_port_pkg::ST_CALL |-> !xfer_strobe_n) else $error("call strobe gap");
   c_call: cover property (@(posedge clk) state_reg == accel_port_pkg::ST_CALL ##1 portIdle);
   c_ret: cover property (@(posedge clk) regWrEn ##1 regWrEn);
   c_store: cover property (@(posedge clk) state_reg == accel_port_pkg::ST_STMEM ##[1:4] memDone);
   c_fault: cover property (@(posedge clk) !xferError_n);
endmodule : accel_data_port

// ---- logic/accel_port_cfg.svh ----
// Purpose: Constants for the accelerator data transfer port
// Assumes: Single 10 MHz clock, synchronous active-high reset
// Notes: Counts and field positions only; types live in the package
`ifndef ACCEL_PORT_CFG_SVH
`define ACCEL_PORT_CFG_SVH
`define DATA_W 32
`define HALF_W 16
`define OP_W 12
`define UNIT_HI 11
`define UNIT_LO 10
`define CNT_HI 6
`define CNT_LO 4
`define FIRST_REG 4'h4
`define MAX_REGS 3'h7
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define GPR_IDX_W 4
`endif

// ---- logic/accel_port_pkg.sv ----
// Purpose: Types for the accelerator data transfer port
// Assumes: Included configuration header supplies the widths
// Notes: Nothing here holds state
`include "accel_port_cfg.svh"
package accel_port_pkg;
   typedef enum logic [2:0] {OP_NONE, OP_CALL, OP_RET, OP_LOAD, OP_STORE} xfer_op_t;
   typedef enum logic [2:0] {ST_IDLE, ST_UPD, ST_CALL, ST_RET, ST_LDWAIT, ST_STACK, ST_STMEM,
      ST_DONE} xfer_state_t;
endpackage : accel_port_pkg

// ---- logic/xfer_fifo.sv ----
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes: Stalls the writer when full
`timescale 1ns/1ps
module xfer_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   wire logic doWrite;
   wire logic doRead;
   assign inReady = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ;
   assign outValid = (count_reg != '0);
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;
   assign outData = mem_reg[rdPtr_reg];
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (doWrite) wrPtr_reg <= wrPtr_reg + AW'(1);
         if (doRead) rdPtr_reg <= rdPtr_reg + AW'(1);
         count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
   always_ff @(posedge clk) begin
      if (doWrite) mem_reg[wrPtr_reg] <= inData;
   end
   a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
      count_reg <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : xfer_fifo

// ---- testbench/accel_model.sv ----
// Purpose: Behavioural accelerator unit on the far side of the data port
// Assumes: Shared lines active low and pulled high when released
// Notes: Ack is combinational from the port's registered outputs
`timescale 1ns/1ps
module accel_model #(
   parameter logic [1:0] UNIT = 2'h1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] accel_opcode,
   input wire logic accel_decode_strobe_n,
   input wire logic accelExecute_n,
   input wire logic xfer_strobe_n,
   input wire logic accelBusOe,
   input wire logic [31:0] accelBusOut,
   input wire logic busyReq,
   input wire logic excReq,
   input wire logic stall,
   input wire logic [31:0] storeData,
   output logic accelBusyIn_n,
   output logic accel_exception_n,
   output logic xfer_ack_n,
   output logic [31:0] accelBusIn
);
   logic [2:0] modeReg;
   logic stPendReg;
   logic [2:0] retCntReg;
   logic [31:0] lastReg;
   logic [31:0] callLog[$];
   wire selected = !accel_decode_strobe_n && accel_opcode[11:10] == UNIT;
   wire callAck = modeReg == 3'h3 && !xfer_strobe_n && accelBusOe && !stall;
   wire retDrv = modeReg == 3'h2 && !xfer_strobe_n && !stall;
   wire stDrv = stPendReg && !excReq;
   assign accelBusyIn_n = selected ? !busyReq : 1'b1;
   assign accel_exception_n = selected ? !excReq : 1'b1;
   assign xfer_ack_n = !(callAck || retDrv || stDrv);
   // Released bus shows the inverse of the last value
   assign accelBusIn = retDrv ? 32'h0DA70000 + 32'(retCntReg) : stDrv ? storeData : ~lastReg;
   always @(posedge clk) begin
      if (rst) begin
         modeReg <= 3'h0;
         stPendReg <= 1'b0;
         retCntReg <= 3'h0;
         lastReg <= 32'h0;
      end else begin
         if (!accelExecute_n) begin
            modeReg <= accel_opcode[9:7];
            retCntReg <= 3'h0;
            stPendReg <= accel_opcode[9] && accel_opcode[7] && !excReq;
         end else if (stDrv) begin
            stPendReg <= 1'b0;
         end
         if (retDrv) begin
            retCntReg <= retCntReg + 3'h1;
         end
         if (retDrv || stDrv) begin
            lastReg <= accelBusIn;
         end
         if (callAck) begin
            callLog.push_back(accelBusOut);
         end
      end
   end
endmodule : accel_model

// ---- testbench/accel_data_port_tb.sv ----
// Purpose: Self-checking bench for the accelerator data transfer port
// Assumes: Opcode bit 8 low selects a half-word memory operand
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module accel_data_port_tb;
   logic clk = 1'b0, rst = 1'b1, accel_decode_strobe_n = 1'b1, issueReq = 1'b0;
   logic issueUpdate = 1'b0, memDone = 1'b0, memFault = 1'b0;
   logic busyReq = 1'b0, excReq = 1'b0, stall = 1'b0;
   logic [11:0] accel_opcode = 12'h0;
   logic [31:0] effAddr = 32'h0, memRdData = 32'h0, storeData = 32'h0;
   logic accelBusyIn_n, accel_exception_n, accelExecute_n, accelExcTaken, accelBusOe;
   logic xfer_strobe_n, xfer_ack_n, xferError_n, regWrEn, memReq, memWrite, memHalf, portIdle;
   logic [31:0] accelBusIn, accelBusOut, regRdData, regWrData, memWrData;
   logic [3:0] regRdIdx, regWrIdx;
   logic [35:0] wrLog[$];
   int failCount = 0, numChecks = 0;
   always #50 clk = ~clk;
   assign regRdData = {28'h5A00000, regRdIdx};
   always @(posedge clk) if (regWrEn === 1'b1) wrLog.push_back({regWrIdx, regWrData});
   accel_data_port u_dut (.clk, .rst, .accel_opcode, .accel_decode_strobe_n, .accelBusyIn_n,
      .accel_exception_n, .issueReq, .issueUpdate, .effAddr, .accelExecute_n, .accelExcTaken,
      .accelBusIn, .accelBusOut, .accelBusOe, .xfer_strobe_n, .xfer_ack_n, .xferError_n,
      .regRdIdx, .regRdData, .regWrEn, .regWrIdx, .regWrData, .memReq, .memWrite, .memHalf,
      .memWrData, .memDone, .memRdData, .memFault, .portIdle);
   accel_model u_acc (.clk, .rst, .accel_opcode, .accel_decode_strobe_n, .accelExecute_n,
      .xfer_strobe_n, .accelBusOe, .accelBusOut, .busyReq, .excReq, .stall, .storeData,
      .accelBusyIn_n, .accel_exception_n, .xfer_ack_n, .accelBusIn);
   task automatic testDone;
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : testDone
   task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
      numChecks++;
      if (got !== exp) begin
         failCount++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic waitLevel(input string what, ref logic sig, input logic lvl);
      for (int i = 0; i < 60 && sig !== lvl; i++) cyc(1);
      if (sig !== lvl) begin
         failCount++;
         $display("Error %s wait ran out", what);
         testDone();
      end
   endtask : waitLevel
   task automatic issue(input logic [11:0] op, input logic upd);
      accel_opcode = op;
      issueUpdate = upd;
      accel_decode_strobe_n = 1'b0;
      issueReq = 1'b1;
      cyc(1);
      accel_decode_strobe_n = 1'b1;
      issueReq = 1'b0;
      check("execute", 36'h0, 36'(accelExecute_n));
   endtask : issue
   task automatic idleCheck(input string what);
      check({what, " strobe"}, 36'h1, 36'(xfer_strobe_n));
      check({what, " error"}, 36'h1, 36'(xferError_n));
      check({what, " idle"}, 36'h1, 36'(portIdle));
   endtask : idleCheck
   task automatic callTest(input logic [2:0] cnt);
      u_acc.callLog.delete();
      issue({2'h1, 3'h3, cnt, 4'h3}, 1'b0);
      cyc(2);
      stall = 1'b1;
      cyc(1);
      stall = 1'b0;
      waitLevel("call end", portIdle, 1'b1);
      check("call count", 36'(cnt), 36'(u_acc.callLog.size()));
      for (int i = 0; i < cnt; i++) check("call word", {4'h0, 28'h5A00000, 4'(4 + i)}, 36'(u_acc.callLog[i]));
      $display("call test done count %0d", cnt);
   endtask : callTest
   task automatic retTest(input logic [2:0] cnt);
      wrLog.delete();
      issue({2'h1, 3'h2, cnt, 4'h5}, 1'b0);
      cyc(2);
      stall = 1'b1;
      cyc(1);
      stall = 1'b0;
      waitLevel("return end", portIdle, 1'b1);
      cyc(1);
      check("return count", 36'(cnt), 36'(wrLog.size()));
      for (int i = 0; i < cnt; i++) check("return write", {4'(4 + i), 32'h0DA70000 + 32'(i)}, wrLog[i]);
      $display("return test done count %0d", cnt);
   endtask : retTest
   task automatic memTest(input logic store, input int waits, input logic fault);
      memRdData = 32'h1234ABCD;
      storeData = 32'h9876FEDC;
      effAddr = 32'h00002F40;
      issue({2'h1, 1'b1, 1'b0, store, 1'b1, 6'h05}, 1'b1);
      waitLevel("update drive", accelBusOe, 1'b1);
      check("update value", 36'(effAddr), 36'(accelBusOut));
      waitLevel("memory request", memReq, 1'b1);
      check("write flag", 36'(store), 36'(memWrite));
      for (int i = 0; i < waits; i++) begin
         cyc(1);
         if (i == 0 && store) check("half data", 36'h00000FEDC, 36'(memWrData));
         check("strobe in wait", 36'h1, 36'(xfer_strobe_n));
      end
      memDone = 1'b1;
      memFault = fault;
      cyc(1);
      memDone = 1'b0;
      memFault = 1'b0;
      check("done strobe", 36'h0, 36'(xfer_strobe_n));
      check("error out", 36'(!fault), 36'(xferError_n));
      if (!store) check("load data", 36'(memRdData), 36'(accelBusOut));
      cyc(1);
      idleCheck("after memory");
      $display("memory test done store %0d", store);
   endtask : memTest
   task automatic excTest;
      excReq = 1'b1;
      issue({2'h1, 3'h3, 3'h2, 4'h0}, 1'b0);
      check("exception taken", 36'h1, 36'(accelExcTaken));
      excReq = 1'b0;
      cyc(3);
      idleCheck("after exception");
      $display("exception test done");
   endtask : excTest
   task automatic busyTest;
      accel_opcode = {2'h1, 3'h3, 3'h0, 4'h1};
      busyReq = 1'b1;
      accel_decode_strobe_n = 1'b0;
      issueReq = 1'b1;
      for (int i = 0; i < 3; i++) begin
         cyc(1);
         check("stalled execute", 36'h1, 36'(accelExecute_n));
      end
      busyReq = 1'b0;
      cyc(1);
      accel_decode_strobe_n = 1'b1;
      issueReq = 1'b0;
      check("released execute", 36'h0, 36'(accelExecute_n));
      cyc(3);
      idleCheck("execute only");
      $display("busy test done");
   endtask : busyTest
   initial begin
      cyc(2);
      rst = 1'b0;
      idleCheck("reset");
      check("reset oe", 36'h0, 36'(accelBusOe));
      callTest(3'h1);
      callTest(3'h7);
      retTest(3'h3);
      memTest(1'b0, 0, 1'b0);
      memTest(1'b0, 2, 1'b1);
      memTest(1'b1, 1, 1'b1);
      excTest();
      busyTest();
      testDone();
   end
endmodule : accel_data_port_tb
